// File: include/dpb_pkg.sv
// Package: constants and types for the diagnostic and inertial packet builder
package dpb_pkg;
   // Clock and timing
   localparam int unsigned CLK_HZ = 40000000;
   localparam int unsigned DIAG_RATE_HZ = 1;
   localparam int unsigned IMU_RATE_HZ = 100;
   localparam int unsigned DIAG_PERIOD_CYC = CLK_HZ / DIAG_RATE_HZ;
   localparam int unsigned IMU_PERIOD_CYC = CLK_HZ / IMU_RATE_HZ;
   localparam int unsigned PULSE_HIGH_CYC = DIAG_PERIOD_CYC / 2;
   // Framing
   localparam logic [15:0] SYNC_WORD = 16'h5555;
   localparam logic [15:0] DIAG_MSG_ID = 16'h0A05;
   localparam logic [15:0] IMU_MSG_ID = 16'h0A01;
   localparam logic [31:0] DIAG_LEN = 32'h0000_0016;
   localparam logic [31:0] IMU_LEN = 32'h0000_001E;
   localparam logic [7:0] FRAME_OVERHEAD = 8'h0A;
   localparam logic [7:0] HDR_BYTES = 8'h08;
   localparam int MAX_PKT = 40;
   localparam logic [15:0] CRC_POLY = 16'h1021;
   localparam logic [15:0] CRC_INIT = 16'h1D0F;
   // Payload byte offsets
   localparam int OFS_WEEK = 0;
   localparam int OFS_MS = 2;
   localparam int OFS_STATUS = 6;
   localparam int OFS_T_IMU = 10;
   localparam int OFS_T_MCU = 14;
   localparam int OFS_T_RCV = 18;
   localparam int OFS_AX = 6;
   localparam int OFS_GX = 18;
   // Status bit positions
   localparam int ST_FAULT_LSB = 0;
   localparam int ST_FAULT_W = 9;
   localparam int ST_TXOVF = 9;
   localparam int ST_PULSE = 10;
   localparam int ST_RCV_LSB = 11;
   localparam int ST_POWER = 13;
   localparam int ST_MCU = 14;
   localparam int ST_UNDER_LSB = 15;
   localparam int ST_OVER_LSB = 18;
   localparam int ST_USED = 21;
   localparam logic [3:0] TXOVF_LIMIT = 4'hA;
   localparam logic [31:0] AXI_STATUS = 32'h0000_0000;
   localparam logic [31:0] AXI_MASK = 32'h0000_0004;
   localparam logic [31:0] AXI_CTRL = 32'h0000_0008;
   localparam logic [31:0] AXI_DSTAT = 32'h0000_000C;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum logic {DPB_KIND_DIAG, DPB_KIND_IMU} dpb_kind_type;
endpackage

// File: include/dpb_ser_if.sv
// Interface: byte request from packet builder to serializer
`timescale 1ns/1ps
`default_nettype none
interface dpb_ser_if;
   logic start;
   logic busy;
   logic [7:0] total;
   logic [7:0] bytes [0:39];
   modport master (output start, output total, output bytes, input busy);
   modport slave (input start, input total, input bytes, output busy);
endinterface
`default_nettype wire

// File: hdl/dpb_serializer.sv
// Serializer: streams a built packet with a trailing CRC-16
`timescale 1ns/1ps
`default_nettype none
module dpb_serializer
   import dpb_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   dpb_ser_if.slave req,
   output logic [7:0] tdata,
   output logic tvalid,
   output logic tlast,
   input wire logic tready
);
   // ------------------------------------------------
   // Byte sender state
   // ------------------------------------------------
   logic [7:0] idx, next_idx;
   logic [15:0] crc, next_crc;
   logic active, next_active;
   logic [7:0] byte_now;

   // CRC-16 over one byte, MSB first
   function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
      logic [15:0] r;
      r = c ^ {d, 8'h00};
      for (int i = 0; i < 8; i++)
      begin
         r = r[15] ? ((r << 1) ^ CRC_POLY) : (r << 1);
      end
      return r;
   endfunction

   // Frame bytes then CRC high then low
   always_comb
   begin
      if (idx < req.total - 8'h02)
      begin
         byte_now = req.bytes[idx[5:0]];
      end
      else if (idx == req.total - 8'h02)
      begin
         byte_now = crc[15:8];
      end
      else
      begin
         byte_now = crc[7:0];
      end
   end

   // Next state
   always_comb
   begin
      next_idx = idx;
      next_crc = crc;
      next_active = active;
      if (!active && req.start)
      begin
         next_active = 1'b1;
         next_idx = 8'h00;
         next_crc = CRC_INIT;
      end
      else if (active && tready)
      begin
         next_idx = idx + 8'h01;
         if (idx >= HDR_BYTES[7:0] - 8'h06 && idx < req.total - 8'h02)
         begin
            next_crc = crc_step(crc, byte_now);
         end
         if (idx == req.total - 8'h01)
         begin
            next_active = 1'b0;
         end
      end
   end

   // Registers
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         idx <= 8'h00;
         crc <= CRC_INIT;
         active <= 1'b0;
      end
      else
      begin
         idx <= next_idx;
         crc <= next_crc;
         active <= next_active;
      end
   end

   assign tdata = byte_now;
   assign tvalid = active;
   assign tlast = active && (idx == req.total - 8'h01);
   assign req.busy = active;
endmodule
`default_nettype wire

// File: hdl/dpb_packet_builder.sv
// Top: diagnostic and raw inertial packet builder with AXI4-Lite registers
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Diagnostic packet once per second, id 0x0A05, payload 22 bytes.
// - Week at byte 0, millisecond time-of-week at byte 2.
// - Status word at byte 6; 1 means faulted, 0 normal.
// - Temperatures: inertial at 10, controller at 14, receiver at 18.
// - Bits 0-4: master, hardware, software, config, calibration faults.
// - Bit 5 acceleration degraded, bit 6 angular rate degraded.
// - Bit 7 forced restart, bit 8 CRC error.
// - Bit 9 only after ten consecutive transmit overflows.
// - Bit 10 pulse fault, 11 receiver silent, 12 no valid signal.
// - Bit 13 power missing, bit 14 controller self-test failure.
// - Second pulse output 1 Hz, 50% duty, rising edge is reference.
// - Raw inertial packet, id 0x0A01, payload 30 bytes, 100 per second.
// - Accelerations x,y,z floats at bytes 6, 10, 14.
// - Angular rates x,y,z floats at bytes 18, 22, 26.
// - Frame: 0x5555, id, 4-byte length, payload, CRC-16.
// - Frame overhead is exactly ten bytes.
module dpb_packet_builder
   import dpb_pkg::*;
#(
   parameter int unsigned DIAG_PERIOD = dpb_pkg::DIAG_PERIOD_CYC,
   parameter int unsigned IMU_PERIOD = dpb_pkg::IMU_PERIOD_CYC
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [15:0] week,
   input wire logic [31:0] millisecs,
   input wire logic [8:0] fault_flags,
   input wire logic tx_overflow_cycle,
   input wire logic tx_overflow,
   input wire logic pulse_fault,
   input wire logic [1:0] receiver_flags,
   input wire logic power_missing,
   input wire logic mcu_selftest_fail,
   input wire logic [2:0] under_temp,
   input wire logic [2:0] over_temp,
   input wire logic [31:0] temp_imu,
   input wire logic [31:0] temp_mcu,
   input wire logic [31:0] temp_rcv,
   input wire logic [95:0] accel_xyz,
   input wire logic [95:0] gyro_xyz,
   output logic second_pulse_output,
   output logic [7:0] tdata,
   output logic tvalid,
   output logic tlast,
   input wire logic tready,
   output logic irq,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   dpb_ser_if ser();

   // ------------------------------------------------
   // Rate dividers and second pulse
   // ------------------------------------------------
   logic [31:0] sec_cnt, next_sec_cnt;
   logic [31:0] imu_cnt, next_imu_cnt;
   logic diag_tick, imu_tick;
   logic enable, next_enable;

   // Second counter drives both the pulse and the diagnostic tick
   always_comb
   begin
      next_sec_cnt = (sec_cnt == DIAG_PERIOD - 1) ? 32'h0000_0000 : sec_cnt + 32'h0000_0001;
      next_imu_cnt = (imu_cnt == IMU_PERIOD - 1) ? 32'h0000_0000 : imu_cnt + 32'h0000_0001;
   end
   assign diag_tick = enable && (sec_cnt == 32'h0000_0000);
   assign imu_tick = enable && (imu_cnt == 32'h0000_0000);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         sec_cnt <= 32'h0000_0000;
         imu_cnt <= 32'h0000_0000;
         second_pulse_output <= 1'b0;
      end
      else
      begin
         sec_cnt <= next_sec_cnt;
         imu_cnt <= next_imu_cnt;
         // High for the first half of each second, rising at count zero
         second_pulse_output <= (next_sec_cnt < DIAG_PERIOD / 2);
      end
   end

   // ------------------------------------------------
   // Status word assembly
   // ------------------------------------------------
   logic [3:0] ovf_run, next_ovf_run;
   logic ovf_flag, next_ovf_flag;
   logic [31:0] status_word;

   // Consecutive overflow counter; a clean cycle restarts the count
   always_comb
   begin
      next_ovf_run = ovf_run;
      next_ovf_flag = ovf_flag;
      if (tx_overflow_cycle)
      begin
         if (!tx_overflow)
         begin
            next_ovf_run = 4'h0;
            next_ovf_flag = 1'b0;
         end
         else if (ovf_run < TXOVF_LIMIT)
         begin
            next_ovf_run = ovf_run + 4'h1;
            next_ovf_flag = (ovf_run + 4'h1 == TXOVF_LIMIT);
         end
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ovf_run <= 4'h0;
         ovf_flag <= 1'b0;
      end
      else
      begin
         ovf_run <= next_ovf_run;
         ovf_flag <= next_ovf_flag;
      end
   end

   // Bits placed by position; unused high bits stay zero
   always_comb
   begin
      status_word = 32'h0000_0000;
      status_word[ST_FAULT_LSB +: ST_FAULT_W] = fault_flags;
      status_word[ST_TXOVF] = ovf_flag;
      status_word[ST_PULSE] = pulse_fault;
      status_word[ST_RCV_LSB +: 2] = receiver_flags;
      status_word[ST_POWER] = power_missing;
      status_word[ST_MCU] = mcu_selftest_fail;
      status_word[ST_UNDER_LSB +: 3] = under_temp;
      status_word[ST_OVER_LSB +: 3] = over_temp;
   end

   // ------------------------------------------------
   // Packet image and launch
   // ------------------------------------------------
   logic diag_pend, next_diag_pend, imu_pend, next_imu_pend;
   logic [7:0] img [0:MAX_PKT-1];
   logic [7:0] next_img [0:MAX_PKT-1];
   logic [7:0] total, next_total;
   logic start, next_start;
   logic [2:0] evt;

   // Little-endian word writer into the image
   function automatic void put32(ref logic [7:0] m [0:MAX_PKT-1], input int at,
                                 input logic [31:0] v);
      for (int b = 0; b < 4; b++)
      begin
         m[at + b] = v[8*b +: 8];
      end
   endfunction

   // Diagnostic takes priority; pending ticks wait while the serializer is busy
   always_comb
   begin
      next_img = img;
      next_total = total;
      next_start = 1'b0;
      next_diag_pend = diag_pend | diag_tick;
      next_imu_pend = imu_pend | imu_tick;
      if (!ser.busy && !start && (diag_pend || imu_pend))
      begin
         next_start = 1'b1;
         next_img[0] = SYNC_WORD[7:0];
         next_img[1] = SYNC_WORD[15:8];
         next_img[8 + OFS_WEEK] = week[7:0];
         next_img[9 + OFS_WEEK] = week[15:8];
         put32(next_img, 8 + OFS_MS, millisecs);
         if (diag_pend)
         begin
            next_diag_pend = diag_tick;
            next_img[2] = DIAG_MSG_ID[7:0];
            next_img[3] = DIAG_MSG_ID[15:8];
            put32(next_img, 4, DIAG_LEN);
            put32(next_img, 8 + OFS_STATUS, status_word);
            put32(next_img, 8 + OFS_T_IMU, temp_imu);
            put32(next_img, 8 + OFS_T_MCU, temp_mcu);
            put32(next_img, 8 + OFS_T_RCV, temp_rcv);
            next_total = DIAG_LEN[7:0] + FRAME_OVERHEAD;
         end
         else
         begin
            next_imu_pend = imu_tick;
            next_img[2] = IMU_MSG_ID[7:0];
            next_img[3] = IMU_MSG_ID[15:8];
            put32(next_img, 4, IMU_LEN);
            for (int a = 0; a < 3; a++)
            begin
               put32(next_img, 8 + OFS_AX + 4*a, accel_xyz[32*a +: 32]);
               put32(next_img, 8 + OFS_GX + 4*a, gyro_xyz[32*a +: 32]);
            end
            next_total = IMU_LEN[7:0] + FRAME_OVERHEAD;
         end
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         diag_pend <= 1'b0;
         imu_pend <= 1'b0;
         start <= 1'b0;
         total <= 8'h00;
         for (int i = 0; i < MAX_PKT; i++)
         begin
            img[i] <= 8'h00;
         end
      end
      else
      begin
         diag_pend <= next_diag_pend;
         imu_pend <= next_imu_pend;
         start <= next_start;
         total <= next_total;
         img <= next_img;
      end
   end

   assign ser.start = start;
   assign ser.total = total;
   assign ser.bytes = img;

   dpb_serializer u_ser (
      .aclk(aclk),
      .aresetn(aresetn),
      .req(ser),
      .tdata(tdata),
      .tvalid(tvalid),
      .tlast(tlast),
      .tready(tready)
   );

   // ------------------------------------------------
   // AXI4-Lite registers and interrupt
   // ------------------------------------------------
   logic [2:0] ev_stat, next_ev_stat, ev_mask, next_ev_mask;
   logic aw_ok, ar_ok;

   // Events: diagnostic sent, inertial sent, overflow flag rise
   assign evt = {next_ovf_flag & ~ovf_flag, tvalid & tready & tlast & (total == IMU_LEN[7:0] + FRAME_OVERHEAD),
                 tvalid & tready & tlast & (total == DIAG_LEN[7:0] + FRAME_OVERHEAD)};
   assign aw_ok = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
   assign ar_ok = s_axi_arvalid && !s_axi_rvalid;

   // Write-one clears; a same-cycle event wins over the clear
   always_comb
   begin
      next_ev_stat = ev_stat;
      next_ev_mask = ev_mask;
      next_enable = enable;
      if (aw_ok && s_axi_wstrb[0])
      begin
         unique case (s_axi_awaddr)
            AXI_STATUS: next_ev_stat = ev_stat & ~s_axi_wdata[2:0];
            AXI_MASK: next_ev_mask = s_axi_wdata[2:0];
            AXI_CTRL: next_enable = s_axi_wdata[0];
            default: next_ev_stat = ev_stat;
         endcase
      end
      next_ev_stat = next_ev_stat | evt;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ev_stat <= 3'h0;
         ev_mask <= 3'h0;
         enable <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp <= RESP_OKAY;
         s_axi_rdata <= 32'h0000_0000;
         irq <= 1'b0;
      end
      else
      begin
         ev_stat <= next_ev_stat;
         ev_mask <= next_ev_mask;
         enable <= next_enable;
         irq <= |(next_ev_stat & next_ev_mask);
         if (aw_ok)
         begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (s_axi_awaddr == AXI_STATUS || s_axi_awaddr == AXI_MASK ||
                            s_axi_awaddr == AXI_CTRL) ? RESP_OKAY : RESP_SLVERR;
         end
         else if (s_axi_bready)
         begin
            s_axi_bvalid <= 1'b0;
         end
         if (ar_ok)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= RESP_OKAY;
            unique case (s_axi_araddr)
               AXI_STATUS: s_axi_rdata <= {29'h0, ev_stat};
               AXI_MASK: s_axi_rdata <= {29'h0, ev_mask};
               AXI_CTRL: s_axi_rdata <= {31'h0, enable};
               AXI_DSTAT: s_axi_rdata <= status_word;
               default:
               begin
                  s_axi_rdata <= 32'h0000_0000;
                  s_axi_rresp <= RESP_SLVERR;
               end
            endcase
         end
         else if (s_axi_rready)
         begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   assign s_axi_awready = aw_ok;
   assign s_axi_wready = aw_ok;
   assign s_axi_arready = ar_ok;

   // ------------------------------------------------
   // Assertions
   // ------------------------------------------------
   property p_pulse_rise;
      @(posedge aclk) disable iff (!aresetn)
      $past(aresetn) && sec_cnt == 32'h0000_0000 |-> second_pulse_output;
   endproperty
   a_pulse_rise: assert property (p_pulse_rise) else $error("pulse not high at second start");

   property p_ovf_needs_run;
      @(posedge aclk) disable iff (!aresetn)
      $rose(ovf_flag) |-> ovf_run == TXOVF_LIMIT;
   endproperty
   a_ovf_needs_run: assert property (p_ovf_needs_run) else $error("overflow flag early");

   property p_reserved_zero;
      @(posedge aclk) disable iff (!aresetn)
      status_word[31:ST_USED] == 11'h000;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("reserved status bits set");

   property p_frame_sync;
      @(posedge aclk) disable iff (!aresetn)
      start |-> ##1 (tvalid && tdata == SYNC_WORD[7:0]);
   endproperty
   a_frame_sync: assert property (p_frame_sync) else $error("frame not opened by sync");

   property p_len_overhead;
      @(posedge aclk) disable iff (!aresetn)
      start |-> (total == img[4] + FRAME_OVERHEAD);
   endproperty
   a_len_overhead: assert property (p_len_overhead) else $error("total not length plus ten");

   property p_diag_id;
      @(posedge aclk) disable iff (!aresetn)
      (start && total == DIAG_LEN[7:0] + FRAME_OVERHEAD) |-> (img[2] == DIAG_MSG_ID[7:0]);
   endproperty
   a_diag_id: assert property (p_diag_id) else $error("diagnostic id wrong");

   property p_imu_id;
      @(posedge aclk) disable iff (!aresetn)
      (start && total == IMU_LEN[7:0] + FRAME_OVERHEAD) |-> (img[2] == IMU_MSG_ID[7:0]);
   endproperty
   a_imu_id: assert property (p_imu_id) else $error("inertial id wrong");

   property p_status_lsb;
      @(posedge aclk) disable iff (!aresetn)
      (start && img[2] == DIAG_MSG_ID[7:0]) |-> img[8 + OFS_STATUS][4:0] == $past(fault_flags[4:0]);
   endproperty
   a_status_lsb: assert property (p_status_lsb) else $error("status byte mismatch");
endmodule
`default_nettype wire

// File: testbench/dpb_host_model.sv
// Host model: receives byte packets and keeps the last one of each kind
`timescale 1ns/1ps
`default_nettype none
module dpb_host_model
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] tdata,
   input wire logic tvalid,
   input wire logic tlast,
   input wire logic stall,
   output logic tready,
   output logic pulse_trusted
);
   logic [7:0] buf_q [0:39];
   logic [7:0] diag_pkt [0:39];
   logic [7:0] imu_pkt [0:39];
   logic tick;
   int n, diag_len, imu_len, diag_cnt, imu_cnt;
   // A slow host takes every other byte, so the sender must hold its byte
   assign tready = !stall || tick;
   // Status bit 10 reads 1 on a pulse fault, so the pulse is trusted on 0
   assign pulse_trusted = (diag_cnt > 0) && !diag_pkt[15][2];
   // Byte capture; a packet is filed by the low byte of its identifier
   always @(posedge aclk)
   begin
      tick <= aresetn && !tick;
      if (!aresetn)
      begin
         n = 0;
         diag_cnt = 0;
         imu_cnt = 0;
      end
      else if (tvalid && tready && n < 40)
      begin
         buf_q[n] = tdata;
         n = n + 1;
         if (tlast && buf_q[2] == 8'h05)
         begin
            diag_pkt = buf_q;
            diag_len = n;
            diag_cnt = diag_cnt + 1;
         end
         else if (tlast)
         begin
            imu_pkt = buf_q;
            imu_len = n;
            imu_cnt = imu_cnt + 1;
         end
         if (tlast)
            n = 0;
      end
   end
endmodule
`default_nettype wire

// File: testbench/tb_top.sv
// Testbench: packet contents, status word, second pulse and register bus
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import dpb_pkg::*;
   localparam int unsigned DP = 2000;
   localparam int unsigned IP = 200;
   logic aclk, aresetn, tx_overflow_cycle, tx_overflow, pulse_fault, power_missing;
   logic mcu_selftest_fail, second_pulse_output, tvalid, tlast, tready, irq, stall, trusted;
   logic [15:0] week;
   logic [31:0] millisecs, temp_imu, temp_mcu, temp_rcv, s_axi_awaddr, s_axi_wdata;
   logic [31:0] s_axi_araddr, s_axi_rdata, d;
   logic [8:0] fault_flags;
   logic [1:0] receiver_flags, s_axi_bresp, s_axi_rresp, r;
   logic [2:0] under_temp, over_temp;
   logic [95:0] accel_xyz, gyro_xyz;
   logic [7:0] tdata;
   logic [3:0] s_axi_wstrb;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [7:0] pk [0:39];
   int pn, fails, total_checks;
   dpb_packet_builder #(.DIAG_PERIOD(DP), .IMU_PERIOD(IP)) dpb_packet_builder_inst (.aclk,
      .aresetn, .week, .millisecs, .fault_flags, .tx_overflow_cycle, .tx_overflow,
      .pulse_fault, .receiver_flags, .power_missing, .mcu_selftest_fail, .under_temp,
      .over_temp, .temp_imu, .temp_mcu, .temp_rcv, .accel_xyz, .gyro_xyz,
      .second_pulse_output, .tdata, .tvalid, .tlast, .tready, .irq, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready);
   dpb_host_model host_inst (.aclk, .aresetn, .tdata, .tvalid, .tlast, .stall, .tready,
      .pulse_trusted(trusted));
   // ---------------------------------------------
   // Shared helpers
   // ---------------------------------------------
   task automatic complete_run;
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      total_checks++;
      if (seen !== exp)
      begin
         fails++;
         $display("BAD %0t %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask
   // Waits are bounded; a hang ends the run as a mismatch
   task automatic await(ref logic s);
      int i;
      i = 0;
      do
      begin
         @(negedge aclk);
         i++;
      end
      while (s !== 1'b1 && i < 1000);
      if (s !== 1'b1)
      begin
         fails++;
         complete_run();
      end
   endtask
   task automatic axi_write(input logic [31:0] a, input logic [31:0] v);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      await(s_axi_awready);
      @(posedge aclk);
      s_axi_awvalid <= 1'b0;
      s_axi_wvalid <= 1'b0;
      await(s_axi_bvalid);
      r = s_axi_bresp;
      @(posedge aclk);
      s_axi_bready <= 1'b0;
   endtask
   task automatic axi_read(input logic [31:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      await(s_axi_arready);
      @(posedge aclk);
      s_axi_arvalid <= 1'b0;
      await(s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      s_axi_rready <= 1'b0;
   endtask
   // Second new packet is taken, so it was launched after inputs settled
   task automatic grab(input logic diag);
      int c0, i;
      c0 = diag ? host_inst.diag_cnt : host_inst.imu_cnt;
      for (i = 0; i < 3 * DP && (diag ? host_inst.diag_cnt : host_inst.imu_cnt) < c0 + 2; i++)
         @(negedge aclk);
      if (i == 3 * DP)
      begin
         fails++;
         complete_run();
      end
      pn = diag ? host_inst.diag_len : host_inst.imu_len;
      for (i = 0; i < 40; i++)
         pk[i] = diag ? host_inst.diag_pkt[i] : host_inst.imu_pkt[i];
   endtask
   // Payload word, least significant byte first
   function automatic logic [31:0] f32(input int ofs);
      return {pk[ofs + 11], pk[ofs + 10], pk[ofs + 9], pk[ofs + 8]};
   endfunction
   task automatic check_frame(input logic [15:0] id, input logic [31:0] len);
      logic [15:0] c;
      int i, b;
      c = CRC_INIT;
      for (i = 2; i < len + 8; i++)
      begin
         c = c ^ {pk[i], 8'h00};
         for (b = 0; b < 8; b++)
            c = c[15] ? ((c << 1) ^ CRC_POLY) : (c << 1);
      end
      check({16'h0, pk[1], pk[0]}, 32'h0000_5555, "sync");
      check({16'h0, pk[3], pk[2]}, {16'h0, id}, "id");
      check(f32(-4), len, "length");
      check(32'(pn), len + 32'hA, "size");
      check({16'h0, pk[len + 8], pk[len + 9]}, {16'h0, c}, "crc");
      check({16'h0, pk[9], pk[8]}, {16'h0, week}, "week");
      check(f32(2), millisecs, "time");
   endtask
   // ---------------------------------------------
   // Scenarios
   // ---------------------------------------------
   task automatic pulse_scn;
      int i, hi, d0, i0;
      for (i = 0; i < 2 * DP && second_pulse_output !== 1'b0; i++)
         @(negedge aclk);
      for (i = 0; i < 2 * DP && second_pulse_output !== 1'b1; i++)
         @(negedge aclk);
      hi = 0;
      d0 = host_inst.diag_cnt;
      i0 = host_inst.imu_cnt;
      for (i = 0; i < DP; i++)
      begin
         hi += (second_pulse_output === 1'b1);
         @(negedge aclk);
      end
      check(32'(hi), DP / 2, "pulse high");
      check(32'(host_inst.diag_cnt - d0), 32'h1, "diag rate");
      check(32'(host_inst.imu_cnt - i0), DP / IP, "imu rate");
   endtask
   task automatic imu_scn;
      int k;
      stall <= 1'b1;
      week <= 16'h1234;
      millisecs <= 32'hA1B2_C3D4;
      accel_xyz <= {32'h4040_0000, 32'h4000_0000, 32'h3F80_0000};
      gyro_xyz <= {32'hC120_0000, 32'h41A0_0000, 32'h4120_0000};
      grab(1'b0);
      check_frame(IMU_MSG_ID, 32'd30);
      for (k = 0; k < 3; k++)
      begin
         check(f32(6 + 4 * k), accel_xyz[32 * k +: 32], "accel");
         check(f32(18 + 4 * k), gyro_xyz[32 * k +: 32], "gyro");
      end
      stall <= 1'b0;
   endtask
   // Two opposite patterns catch status bits other than bit 9 stuck either way
   task automatic diag_scn;
      int p;
      for (p = 0; p < 2; p++)
      begin
         @(posedge aclk);
         fault_flags <= p ? 9'h0AA : 9'h155;
         pulse_fault <= !p;
         receiver_flags <= p ? 2'h1 : 2'h2;
         power_missing <= p;
         mcu_selftest_fail <= !p;
         under_temp <= p ? 3'h4 : 3'h3;
         over_temp <= p ? 3'h3 : 3'h4;
         temp_imu <= 32'h41C8_0000 + p;
         temp_mcu <= 32'h4220_0000;
         temp_rcv <= 32'hC0A0_0000;
         grab(1'b1);
         check_frame(DIAG_MSG_ID, 32'd22);
         check(f32(6), p ? 32'h000E_28AA : 32'h0011_D555, "status");
         check(f32(10), temp_imu, "t imu");
         check(f32(14), temp_mcu, "t mcu");
         check(f32(18), temp_rcv, "t rcv");
         check(32'(trusted), 32'(p), "trust");
      end
   endtask
   task automatic ovf(input int cnt, input logic ov);
      repeat (cnt)
      begin
         @(posedge aclk);
         tx_overflow_cycle <= 1'b1;
         tx_overflow <= ov;
         @(posedge aclk);
         tx_overflow_cycle <= 1'b0;
      end
   endtask
   task automatic ovf_irq_scn;
      ovf(9, 1'b1);
      ovf(1, 1'b0);
      ovf(9, 1'b1);
      axi_read(AXI_DSTAT);
      check({31'h0, d[9]}, 32'h0, "nine overflows");
      check({31'h0, irq}, 32'h0, "irq masked");
      ovf(1, 1'b1);
      axi_read(AXI_DSTAT);
      check({31'h0, d[9]}, 32'h1, "ten overflows");
      axi_write(AXI_MASK, 32'h0000_0004);
      repeat (2) @(negedge aclk);
      check({31'h0, irq}, 32'h1, "irq raised");
      axi_write(AXI_STATUS, 32'h0000_0004);
      repeat (2) @(negedge aclk);
      check({31'h0, irq}, 32'h0, "irq cleared");
      axi_read(32'h0000_0040);
      check({30'h0, r}, {30'h0, RESP_SLVERR}, "unmapped resp");
      check(d, 32'h0, "unmapped data");
   endtask
   // ---------------------------------------------
   // Clock, reset and main sequence
   // ---------------------------------------------
   initial
   begin
      aclk = 1'b0;
      forever #12.5 aclk = ~aclk;
   end
   initial
   begin
      {aresetn, tx_overflow_cycle, tx_overflow, pulse_fault, power_missing} = '0;
      {mcu_selftest_fail, stall, week, millisecs, fault_flags, receiver_flags} = '0;
      {under_temp, over_temp, temp_imu, temp_mcu, temp_rcv, accel_xyz, gyro_xyz} = '0;
      {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
      s_axi_wstrb = 4'hF;
      fails = 0;
      total_checks = 0;
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      pulse_scn();
      imu_scn();
      diag_scn();
      ovf_irq_scn();
      complete_run();
   end
endmodule
`default_nettype wire
